// file: design/dbch_sync.sv
// Purpose: two flip-flop synchroniser for levels and gray words
// Assumes: async active-high reset
// Notes: only the second stage may be read
`timescale 1ns/10ps
`default_nettype none
module dbch_sync #(
   parameter int             W    = 1,
   parameter logic [W-1:0]   INIT = '0
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] nxt_meta;
   logic [W-1:0] q_ff;
   logic [W-1:0] nxt_q;

   always_comb begin
      nxt_meta = d;
      nxt_q    = meta_ff;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_ff <= INIT;
         q_ff    <= INIT;
      end else begin
         meta_ff <= nxt_meta;
         q_ff    <= nxt_q;
      end
   end

   assign q = q_ff;
endmodule // dbch_sync
`default_nettype wire

// file: design/dbch_top.sv
// Purpose: empty, soft restore, error count and power read commands
// Assumes: link layer hands over decoded command bytes on LINK_CLK
// Notes: command and reply bytes cross by toggle handshake
`timescale 1ns/10ps
`default_nettype none
`include "dbch_params.svh"
module dbch_top #(
   parameter int RELOAD_CYCLES = `DBCH_RELOAD_CYC
) (
   input  wire logic             CLK,
   input  wire logic             RESET,
   input  wire logic             LINK_CLK,
   input  wire logic             LINK_CMD_VALID,
   input  wire logic [7:0]       LINK_CMD,
   output logic                  LINK_CMD_READY,
   input  wire logic             LINK_ERR,
   output logic      [7:0]       LINK_RD_DATA,
   output logic                  LINK_RD_VALID,
   input  wire logic             LINK_RD_DONE,
   input  wire logic             MEM_WRITE_BUSY,
   output logic                  MEM_WRITE_STOP,
   input  wire logic             MODE_LOAD,
   input  wire dbch_pkg::dbch_mode_t MODE_IN,
   input  wire logic             BOOSTER_OK,
   output logic                  DISPLAY_BLANK,
   output logic                  DEFAULTS_LOAD,
   output logic                  RELOAD_BUSY,
   output logic                  SIGMODE_D0_CLR,
   output logic      [7:0]       POWER_STATUS,
   output logic      [7:0]       ERROR_COUNT
);

   // ---------------- link domain ----------------
   logic       lk_rst;
   logic [1:0] lk_sync_q;
   logic       lk_cmd_ack_s;
   logic       lk_rsp_req_s;
   logic       cmd_ack_ff;
   logic       rsp_req_ff;
   logic [7:0] rsp_data_ff;

   dbch_sync #(.W(1), .INIT(1'b1)) u_lk_rst (
      .clk (LINK_CLK),
      .rst (RESET),
      .d   (1'b0),
      .q   (lk_rst)
   );

   dbch_sync #(.W(2)) u_lk_sync (
      .clk (LINK_CLK),
      .rst (lk_rst),
      .d   ({cmd_ack_ff, rsp_req_ff}),
      .q   (lk_sync_q)
   );
   assign lk_cmd_ack_s = lk_sync_q[1];
   assign lk_rsp_req_s = lk_sync_q[0];

   logic [7:0] lk_cmd_ff;
   logic [7:0] nxt_lk_cmd;
   logic       lk_cmd_tgl_ff;
   logic       nxt_lk_cmd_tgl;
   logic [3:0] lk_err_bin_ff;
   logic [3:0] nxt_lk_err_bin;
   logic [3:0] lk_err_gray_ff;
   logic [3:0] nxt_lk_err_gray;
   logic [7:0] lk_rd_data_ff;
   logic [7:0] nxt_lk_rd_data;
   logic       lk_rd_valid_ff;
   logic       nxt_lk_rd_valid;
   logic       lk_rsp_ack_ff;
   logic       nxt_lk_rsp_ack;

   // one command in flight; ready returns once the core has taken it
   assign LINK_CMD_READY = (lk_cmd_tgl_ff == lk_cmd_ack_s);

   always_comb begin
      nxt_lk_cmd      = lk_cmd_ff;
      nxt_lk_cmd_tgl  = lk_cmd_tgl_ff;
      nxt_lk_err_bin  = lk_err_bin_ff;
      nxt_lk_rd_data  = lk_rd_data_ff;
      nxt_lk_rd_valid = lk_rd_valid_ff;
      nxt_lk_rsp_ack  = lk_rsp_ack_ff;
      if (LINK_CMD_VALID && LINK_CMD_READY) begin
         nxt_lk_cmd     = LINK_CMD;
         nxt_lk_cmd_tgl = ~lk_cmd_tgl_ff;
      end
      // gray count so bursts of errors survive the crossing
      if (LINK_ERR) begin
         nxt_lk_err_bin = lk_err_bin_ff + 4'h1;
      end
      if (!lk_rd_valid_ff && (lk_rsp_req_s != lk_rsp_ack_ff)) begin
         nxt_lk_rd_data  = rsp_data_ff;
         nxt_lk_rd_valid = 1'b1;
      end else if (lk_rd_valid_ff && LINK_RD_DONE) begin
         nxt_lk_rd_valid = 1'b0;
         nxt_lk_rsp_ack  = ~lk_rsp_ack_ff;
      end
      nxt_lk_err_gray = nxt_lk_err_bin ^ {1'b0, nxt_lk_err_bin[3:1]};
   end

   always_ff @(posedge LINK_CLK or posedge lk_rst) begin
      if (lk_rst) begin
         lk_cmd_ff      <= 8'h00;
         lk_cmd_tgl_ff  <= 1'b0;
         lk_err_bin_ff  <= 4'h0;
         lk_err_gray_ff <= 4'h0;
         lk_rd_data_ff  <= 8'h00;
         lk_rd_valid_ff <= 1'b0;
         lk_rsp_ack_ff  <= 1'b0;
      end else begin
         lk_cmd_ff      <= nxt_lk_cmd;
         lk_cmd_tgl_ff  <= nxt_lk_cmd_tgl;
         lk_err_bin_ff  <= nxt_lk_err_bin;
         lk_err_gray_ff <= nxt_lk_err_gray;
         lk_rd_data_ff  <= nxt_lk_rd_data;
         lk_rd_valid_ff <= nxt_lk_rd_valid;
         lk_rsp_ack_ff  <= nxt_lk_rsp_ack;
      end
   end

   assign LINK_RD_DATA  = lk_rd_data_ff;
   assign LINK_RD_VALID = lk_rd_valid_ff;

   // ---------------- core domain ----------------
   logic [6:0] core_sync_q;
   logic       s_cmd_tgl;
   logic       s_rsp_ack;
   logic       s_boost;
   logic [3:0] s_gray;

   dbch_sync #(.W(7)) u_core_sync (
      .clk (CLK),
      .rst (RESET),
      .d   ({lk_cmd_tgl_ff, lk_rsp_ack_ff, BOOSTER_OK, lk_err_gray_ff}),
      .q   (core_sync_q)
   );
   assign s_cmd_tgl = core_sync_q[6];
   assign s_rsp_ack = core_sync_q[5];
   assign s_boost   = core_sync_q[4];
   assign s_gray    = core_sync_q[3:0];

   function automatic logic [3:0] gray2bin(input logic [3:0] g);
      logic [3:0] b;
      b[3] = g[3];
      b[2] = b[3] ^ g[2];
      b[1] = b[2] ^ g[1];
      b[0] = b[1] ^ g[0];
      return b;
   endfunction

   // command held stable in lk_cmd_ff until the ack toggle returns
   logic       cmd_new;
   logic [7:0] cmd;
   logic       rsp_done;
   logic       ack_d_ff;
   assign cmd_new  = (s_cmd_tgl != cmd_ack_ff);
   assign cmd      = lk_cmd_ff;
   assign rsp_done = (s_rsp_ack != ack_d_ff);

   dbch_pkg::dbch_state_t state_ff;
   dbch_pkg::dbch_state_t nxt_state;
   dbch_pkg::dbch_mode_t  mode_ff;
   dbch_pkg::dbch_mode_t  nxt_mode;
   logic [`DBCH_RELOAD_W-1:0] reload_ff;
   logic [`DBCH_RELOAD_W-1:0] nxt_reload;
   logic       nxt_cmd_ack;
   logic       nxt_rsp_req;
   logic [7:0] nxt_rsp_data;
   logic       rsp_err_ff;
   logic       nxt_rsp_err;
   logic       blank_ff;
   logic       nxt_blank;
   logic       stop_ff;
   logic       nxt_stop;
   logic       dflt_ff;
   logic       nxt_dflt;
   logic       sigclr_ff;
   logic       nxt_sigclr;
   logic       soft_hit;
   logic       err_clear;
   logic [7:0] pwr_byte;
   logic [7:0] err_byte;

   // booster reads off while asleep so reset shows exactly 08h
   always_comb begin
      pwr_byte = 8'h00;
      pwr_byte[`DBCH_PWR_BOOST_BIT]  = s_boost & mode_ff.awake;
      pwr_byte[`DBCH_PWR_IDLE_BIT]   = mode_ff.idle;
      pwr_byte[`DBCH_PWR_AWAKE_BIT]  = mode_ff.awake;
      pwr_byte[`DBCH_PWR_NORMAL_BIT] = mode_ff.normal;
      pwr_byte[`DBCH_PWR_DISP_BIT]   = mode_ff.disp_on;
   end

   always_comb begin
      nxt_state    = state_ff;
      nxt_mode     = mode_ff;
      nxt_reload   = reload_ff;
      nxt_cmd_ack  = cmd_ack_ff;
      nxt_rsp_req  = rsp_req_ff;
      nxt_rsp_data = rsp_data_ff;
      nxt_rsp_err  = rsp_err_ff;
      nxt_blank    = blank_ff;
      nxt_stop     = 1'b0;
      nxt_dflt     = 1'b0;
      nxt_sigclr   = 1'b0;
      soft_hit     = 1'b0;
      err_clear    = 1'b0;
      if (MODE_LOAD) begin
         nxt_mode = MODE_IN;
         if (MODE_IN.disp_on) begin
            nxt_blank = 1'b0;
         end
      end
      if (rsp_done && rsp_err_ff) begin
         err_clear  = 1'b1;
         nxt_sigclr = 1'b1;
      end
      if (cmd_new) begin
         nxt_cmd_ack = s_cmd_tgl;
      end
      case (state_ff)
         dbch_pkg::DBCH_IDLE, dbch_pkg::DBCH_RESP: begin
            if (state_ff == dbch_pkg::DBCH_RESP && rsp_done) begin
               nxt_state = dbch_pkg::DBCH_IDLE;
            end
            // no mode gate: every state of the panel takes these
            if (cmd_new) begin
               case (cmd)
                  `DBCH_CMD_EMPTY: begin
                     nxt_stop = MEM_WRITE_BUSY;
                  end
                  `DBCH_CMD_SOFT: begin
                     soft_hit   = 1'b1;
                     nxt_state  = dbch_pkg::DBCH_RELOAD;
                     nxt_reload = `DBCH_RELOAD_W'(RELOAD_CYCLES - 1);
                  end
                  `DBCH_CMD_ERR_RD, `DBCH_CMD_PWR_RD: begin
                     // a second read before the first is out is dropped
                     if (state_ff == dbch_pkg::DBCH_IDLE) begin
                        nxt_state    = dbch_pkg::DBCH_RESP;
                        nxt_rsp_req  = ~rsp_req_ff;
                        nxt_rsp_err  = (cmd == `DBCH_CMD_ERR_RD);
                        nxt_rsp_data = (cmd == `DBCH_CMD_ERR_RD) ? err_byte : pwr_byte;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         dbch_pkg::DBCH_RELOAD: begin
            // commands in this window are taken and dropped
            if (reload_ff == '0) begin
               nxt_state = dbch_pkg::DBCH_IDLE;
            end else begin
               nxt_reload = reload_ff - `DBCH_RELOAD_W'(1);
            end
         end
         default: begin
            nxt_state = dbch_pkg::DBCH_IDLE;
         end
      endcase
      if (soft_hit) begin
         nxt_blank = 1'b1;
         nxt_dflt  = 1'b1;
         nxt_mode  = dbch_pkg::dbch_mode_t'(4'h2);
         nxt_stop  = MEM_WRITE_BUSY;
         err_clear = 1'b1;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         state_ff    <= dbch_pkg::DBCH_IDLE;
         mode_ff     <= dbch_pkg::dbch_mode_t'(4'h2);
         reload_ff   <= '0;
         cmd_ack_ff  <= 1'b0;
         ack_d_ff    <= 1'b0;
         rsp_req_ff  <= 1'b0;
         rsp_data_ff <= 8'h00;
         rsp_err_ff  <= 1'b0;
         blank_ff    <= 1'b1;
         stop_ff     <= 1'b0;
         dflt_ff     <= 1'b0;
         sigclr_ff   <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         mode_ff     <= nxt_mode;
         reload_ff   <= nxt_reload;
         cmd_ack_ff  <= nxt_cmd_ack;
         ack_d_ff    <= s_rsp_ack;
         rsp_req_ff  <= nxt_rsp_req;
         rsp_data_ff <= nxt_rsp_data;
         rsp_err_ff  <= nxt_rsp_err;
         blank_ff    <= nxt_blank;
         stop_ff     <= nxt_stop;
         dflt_ff     <= nxt_dflt;
         sigclr_ff   <= nxt_sigclr;
      end
   end

   // ---------------- error counter ----------------
   logic [3:0] err_last_ff;
   logic [3:0] nxt_err_last;
   logic [6:0] cnt_ff;
   logic [6:0] nxt_cnt;
   logic       ovf_ff;
   logic       nxt_ovf;
   logic [3:0] delta;
   logic [7:0] sum;

   // clear and new errors in one cycle: the new errors are kept
   always_comb begin
      nxt_err_last = gray2bin(s_gray);
      delta        = nxt_err_last - err_last_ff;
      if (err_clear) begin
         sum     = {4'h0, delta};
         nxt_ovf = 1'b0;
      end else begin
         sum     = {1'b0, cnt_ff} + {4'h0, delta};
         nxt_ovf = ovf_ff | sum[7];
      end
      nxt_cnt = sum[6:0];
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         err_last_ff <= 4'h0;
         cnt_ff      <= 7'(`DBCH_ERR_RST);
         ovf_ff      <= 1'b0;
      end else begin
         err_last_ff <= nxt_err_last;
         cnt_ff      <= nxt_cnt;
         ovf_ff      <= nxt_ovf;
      end
   end

   always_comb begin
      err_byte = {1'b0, cnt_ff};
      err_byte[`DBCH_ERR_OVF_BIT] = ovf_ff;
   end

   // ---------------- outputs ----------------
   logic [7:0] pwr_out_ff;
   logic [7:0] err_out_ff;

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         pwr_out_ff <= `DBCH_PWR_RST;
         err_out_ff <= `DBCH_ERR_RST;
      end else begin
         pwr_out_ff <= pwr_byte;
         err_out_ff <= err_byte;
      end
   end

   assign POWER_STATUS   = pwr_out_ff;
   assign ERROR_COUNT    = err_out_ff;
   assign DISPLAY_BLANK  = blank_ff;
   assign DEFAULTS_LOAD  = dflt_ff;
   assign MEM_WRITE_STOP = stop_ff;
   assign SIGMODE_D0_CLR = sigclr_ff;
   assign RELOAD_BUSY    = (state_ff == dbch_pkg::DBCH_RELOAD);

endmodule // dbch_top
`default_nettype wire

// file: inc/dbch_params.svh
// Purpose: constants of the display basic command handler
// Assumes: core clock of 125 MHz
// Notes: types live in dbch_pkg
// Operation
// - empty command changes no state
// - empty command ends frame memory write
// - soft restore returns all defaults
// - soft restore blanks display at once
// - defaults reloaded within 5 ms, host waits
// - four commands accepted in every state
// - error read returns 7-bit link error count
// - top bit flags count overflow, sticky
// - full read clears byte and signal bit
// - power read byte, bits 5,1,0 zero
// - bit 7 shows booster on and healthy
// - bits 6,4,3,2 show idle,awake,normal,on
// - power status resets to 08h
`ifndef DBCH_PARAMS_SVH
`define DBCH_PARAMS_SVH

`define DBCH_CMD_EMPTY      8'h00
`define DBCH_CMD_SOFT       8'h01
`define DBCH_CMD_ERR_RD     8'h05
`define DBCH_CMD_PWR_RD     8'h0A

`define DBCH_ERR_RST        8'h00
`define DBCH_PWR_RST        8'h08

`define DBCH_PWR_BOOST_BIT  7
`define DBCH_PWR_IDLE_BIT   6
`define DBCH_PWR_AWAKE_BIT  4
`define DBCH_PWR_NORMAL_BIT 3
`define DBCH_PWR_DISP_BIT   2
`define DBCH_ERR_OVF_BIT    7

`define DBCH_CLK_PERIOD_NS  8
`define DBCH_RELOAD_MS      5
`define DBCH_RELOAD_CYC     ((`DBCH_RELOAD_MS * 1000000) / `DBCH_CLK_PERIOD_NS)
`define DBCH_RELOAD_W       20

`endif

// file: inc/dbch_pkg.sv
// Purpose: shared types of the display basic command handler
// Assumes: nothing
// Notes: constants live in dbch_params.svh
package dbch_pkg;

   typedef enum logic [1:0] {
      DBCH_IDLE   = 2'h0,
      DBCH_RESP   = 2'h1,
      DBCH_RELOAD = 2'h3
   } dbch_state_t;

   typedef struct packed {
      logic idle;
      logic awake;
      logic normal;
      logic disp_on;
   } dbch_mode_t;

endpackage

// file: sim/dbch_host.sv
// Purpose: host side of the command link
// Assumes: drives just after falling link edges
// Notes: idle command lines show the inverse of the last byte
`timescale 1ns/10ps
`default_nettype none
module dbch_host (
   input  wire logic       lclk,
   input  wire logic       cmd_ready,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_valid,
   output var logic        valid,
   output var logic  [7:0] cmd,
   output var logic        err,
   output var logic        done
);
   initial begin
      valid = 1'b0;
      cmd = 8'hFF;
      err = 1'b0;
      done = 1'b0;
   end
   // one byte per command, held until taken
   task automatic send(input logic [7:0] c);
      @(negedge lclk) valid = 1'b1;
      cmd = c;
      while (cmd_ready !== 1'b1) @(negedge lclk);
      @(negedge lclk) valid = 1'b0;
      cmd = ~c;
      @(negedge lclk);
   endtask
   task automatic rd(input logic [7:0] c, output logic [7:0] d);
      send(c);
      while (rd_valid !== 1'b1) @(negedge lclk);
      d = rd_data;
      done = 1'b1;
      @(negedge lclk) done = 1'b0;
      // next read only once the clear has reached the core
      repeat (10) @(negedge lclk);
   endtask
   task automatic errs(input int n);
      repeat (n) begin
         @(negedge lclk) err = 1'b1;
         @(negedge lclk) err = 1'b0;
         repeat (2) @(negedge lclk);
      end
   endtask
endmodule // dbch_host
`default_nettype wire

// file: sim/dbch_top_bench.sv
// Purpose: self-checking bench of dbch_top
// Assumes: reload shortened to 20 cycles
// Notes: host never issues sleep exit, so host waits hold trivially
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module dbch_top_bench;
   logic                 clk, lclk, rst, busy, mload, boost;
   dbch_pkg::dbch_mode_t mode;
   wire logic            valid, ready, lerr, rdv, done, stop, blank, dload, rbusy, clr;
   wire logic [7:0]      cmd, rdd, pwr, errc;
   logic [7:0]           d;
   int                   err_total = 0, n_tests = 0, stop_n = 0, clr_n = 0, dl_n = 0, n, i;
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      lclk = 1'b0;
      #3;
      forever #7.5 lclk = ~lclk;
   end
   // pulses counted on the falling edge, half a cycle after the launching edge
   always @(negedge clk) if (stop === 1'b1) stop_n++;
   always @(negedge clk) if (clr === 1'b1) clr_n++;
   always @(negedge clk) if (dload === 1'b1) dl_n++;
   dbch_top #(.RELOAD_CYCLES(20)) i_dbch_top (.CLK(clk), .RESET(rst), .LINK_CLK(lclk),
      .LINK_CMD_VALID(valid), .LINK_CMD(cmd), .LINK_CMD_READY(ready), .LINK_ERR(lerr),
      .LINK_RD_DATA(rdd), .LINK_RD_VALID(rdv), .LINK_RD_DONE(done), .MEM_WRITE_BUSY(busy),
      .MEM_WRITE_STOP(stop), .MODE_LOAD(mload), .MODE_IN(mode), .BOOSTER_OK(boost),
      .DISPLAY_BLANK(blank), .DEFAULTS_LOAD(dload), .RELOAD_BUSY(rbusy),
      .SIGMODE_D0_CLR(clr), .POWER_STATUS(pwr), .ERROR_COUNT(errc));
   dbch_host i_dbch_host (.lclk(lclk), .cmd_ready(ready), .rd_data(rdd), .rd_valid(rdv),
      .valid(valid), .cmd(cmd), .err(lerr), .done(done));
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic settle(input int k);
      repeat (k) @(negedge clk);
   endtask
   initial begin
      #200000;
      err_total++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      busy = 1'b0;
      mload = 1'b0;
      boost = 1'b0;
      mode = '0;
      repeat (12) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      settle(8);
      `CHK(pwr, 8'h08)
      `CHK(errc, 8'h00)
      `CHK(blank, 1'b1)
      i_dbch_host.rd(8'h0A, d);
      `CHK(d, 8'h08)
      $display("reset test done");
      n = stop_n;
      @(negedge clk) busy = 1'b1;
      i_dbch_host.send(8'h00);
      settle(20);
      `CHK(stop_n, n + 1)
      `CHK(pwr, 8'h08)
      // unknown code: acked, no stop
      i_dbch_host.send(8'h3C);
      settle(20);
      `CHK(stop_n, n + 1)
      @(negedge clk) busy = 1'b0;
      i_dbch_host.send(8'h00);
      settle(20);
      `CHK(stop_n, n + 1)
      `CHK(pwr, 8'h08)
      $display("empty test done");
      @(negedge clk) mload = 1'b1;
      mode = '{idle: 1'b1, awake: 1'b1, normal: 1'b1, disp_on: 1'b1};
      boost = 1'b1;
      @(negedge clk) mload = 1'b0;
      settle(6);
      `CHK(pwr, 8'hDC)
      i_dbch_host.rd(8'h0A, d);
      `CHK(d, 8'hDC)
      `CHK(blank, 1'b0)
      @(negedge clk) boost = 1'b0;
      settle(6);
      i_dbch_host.rd(8'h0A, d);
      `CHK(d, 8'h5C)
      $display("power test done");
      n = clr_n;
      i_dbch_host.errs(3);
      i_dbch_host.rd(8'h05, d);
      `CHK(d, 8'h03)
      `CHK(clr_n, n + 1)
      i_dbch_host.rd(8'h05, d);
      `CHK(d, 8'h00)
      i_dbch_host.errs(129);
      settle(8);
      `CHK(errc, 8'h81)
      i_dbch_host.rd(8'h05, d);
      `CHK(d, 8'h81)
      i_dbch_host.rd(8'h05, d);
      `CHK(d, 8'h00)
      $display("error test done");
      n = stop_n;
      i_dbch_host.errs(2);
      @(negedge clk) busy = 1'b1;
      // no sleep exit is ever sent after this, so no wait is owed
      i_dbch_host.send(8'h01);
      i = 0;
      while (rbusy !== 1'b1 && i < 100) begin
         settle(1);
         i++;
      end
      `CHK(blank, 1'b1)
      // host holds off until the reload is over
      while (rbusy !== 1'b0 && i < 200) begin
         settle(1);
         i++;
      end
      `CHK(rbusy, 1'b0)
      @(negedge clk) busy = 1'b0;
      `CHK(stop_n, n + 1)
      `CHK(dl_n, 1)
      `CHK(errc, 8'h00)
      `CHK(pwr, 8'h08)
      i_dbch_host.rd(8'h0A, d);
      `CHK(d, 8'h08)
      i_dbch_host.rd(8'h05, d);
      `CHK(d, 8'h00)
      $display("restore test done");
      // asleep: booster reads off even when healthy
      @(negedge clk) mload = 1'b1;
      mode = '{idle: 1'b1, awake: 1'b0, normal: 1'b1, disp_on: 1'b1};
      boost = 1'b1;
      @(negedge clk) mload = 1'b0;
      settle(6);
      i_dbch_host.rd(8'h0A, d);
      `CHK(d, 8'h4C)
      i_dbch_host.errs(1);
      settle(8);
      `CHK(errc, 8'h01)
      @(negedge clk) rst = 1'b1;
      settle(12);
      @(negedge clk) rst = 1'b0;
      settle(8);
      `CHK(pwr, 8'h08)
      `CHK(errc, 8'h00)
      `CHK(blank, 1'b1)
      i_dbch_host.rd(8'h0A, d);
      `CHK(d, 8'h08)
      $display("second reset test done");
      conclude();
   end
endmodule // dbch_top_bench
`default_nettype wire

// file: sim/dbch_top_chk.sv
// Purpose: port checks of dbch_top
// Assumes: RELOAD_CYCLES shortened in simulation
// Notes: reset disables every check
`timescale 1ns/10ps
`default_nettype none
module dbch_top_chk #(
   parameter int RELOAD_CYCLES = 20
) (
   input wire logic       CLK,
   input wire logic       RESET,
   input wire logic       LINK_CLK,
   input wire logic       LINK_CMD_VALID,
   input wire logic       LINK_CMD_READY,
   input wire logic [7:0] LINK_RD_DATA,
   input wire logic       LINK_RD_VALID,
   input wire logic       LINK_RD_DONE,
   input wire logic       MEM_WRITE_BUSY,
   input wire logic       MEM_WRITE_STOP,
   input wire logic       DISPLAY_BLANK,
   input wire logic       DEFAULTS_LOAD,
   input wire logic       RELOAD_BUSY,
   input wire logic       SIGMODE_D0_CLR,
   input wire logic [7:0] POWER_STATUS,
   input wire logic [7:0] ERROR_COUNT
);
   logic [31:0] run_ff;
   logic [31:0] nxt_run;
   always_comb begin
      nxt_run = RELOAD_BUSY ? run_ff + 32'h1 : 32'h0;
   end
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) run_ff <= 32'h0;
      else run_ff <= nxt_run;
   end
   stop_cause_a: assert property (@(posedge CLK) disable iff (RESET)
      MEM_WRITE_STOP |-> $past(MEM_WRITE_BUSY) ##1 !MEM_WRITE_STOP) else $error("write stop without busy");
   blank_now_a: assert property (@(posedge CLK) disable iff (RESET)
      DEFAULTS_LOAD |-> DISPLAY_BLANK && RELOAD_BUSY ##1 !DEFAULTS_LOAD) else $error("restore did not blank");
   restore_vals_a: assert property (@(posedge CLK) disable iff (RESET)
      DEFAULTS_LOAD |=> POWER_STATUS == 8'h08 && ERROR_COUNT == 8'h00) else $error("defaults not restored");
   reload_len_a: assert property (@(posedge CLK) disable iff (RESET)
      $fell(RELOAD_BUSY) |-> run_ff >= RELOAD_CYCLES && run_ff <= RELOAD_CYCLES + 1) else $error("reload length");
   pwr_zero_a: assert property (@(posedge CLK) disable iff (RESET)
      (POWER_STATUS & 8'h23) == 8'h00 && (!POWER_STATUS[7] || POWER_STATUS[4])) else $error("power byte bits");
   err_clear_a: assert property (@(posedge CLK) disable iff (RESET)
      SIGMODE_D0_CLR |=> ERROR_COUNT == 8'h00 && !SIGMODE_D0_CLR) else $error("error byte not cleared");
   ovf_sticky_a: assert property (@(posedge CLK) disable iff (RESET)
      ERROR_COUNT[7] && !SIGMODE_D0_CLR && !DEFAULTS_LOAD |=> ERROR_COUNT[7]) else $error("overflow flag lost");
   cmd_take_a: assert property (@(posedge LINK_CLK) disable iff (RESET)
      LINK_CMD_VALID && LINK_CMD_READY |=> !LINK_CMD_READY) else $error("command not taken");
   reply_hold_a: assert property (@(posedge LINK_CLK) disable iff (RESET)
      LINK_RD_VALID && !LINK_RD_DONE |=> LINK_RD_VALID && $stable(LINK_RD_DATA)) else $error("reply dropped");
   restore_c: cover property (@(posedge CLK) disable iff (RESET) DEFAULTS_LOAD);
   clear_c: cover property (@(posedge CLK) disable iff (RESET) SIGMODE_D0_CLR);
   stop_c: cover property (@(posedge CLK) disable iff (RESET) MEM_WRITE_STOP);
endmodule // dbch_top_chk
bind dbch_top dbch_top_chk #(.RELOAD_CYCLES(RELOAD_CYCLES)) i_dbch_top_chk (.CLK(CLK), .RESET(RESET),
   .LINK_CLK(LINK_CLK), .LINK_CMD_VALID(LINK_CMD_VALID), .LINK_CMD_READY(LINK_CMD_READY),
   .LINK_RD_DATA(LINK_RD_DATA), .LINK_RD_VALID(LINK_RD_VALID), .LINK_RD_DONE(LINK_RD_DONE),
   .MEM_WRITE_BUSY(MEM_WRITE_BUSY), .MEM_WRITE_STOP(MEM_WRITE_STOP), .DISPLAY_BLANK(DISPLAY_BLANK),
   .DEFAULTS_LOAD(DEFAULTS_LOAD), .RELOAD_BUSY(RELOAD_BUSY), .SIGMODE_D0_CLR(SIGMODE_D0_CLR),
   .POWER_STATUS(POWER_STATUS), .ERROR_COUNT(ERROR_COUNT));
`default_nettype wire
